// file: verilog/dasy_pkg.sv
`default_nettype none
package dasy_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WIN1 = 8'h04;
	localparam logic [7:0] OFS_WIN2 = 8'h08;
	localparam logic [7:0] OFS_BRAKE = 8'h0C;
	localparam logic [7:0] OFS_LOOPG = 8'h10;
	localparam logic [7:0] OFS_LAG = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [2:0] AXIS1_PAGE = 3'h1;
	localparam logic [2:0] AXIS2_PAGE = 3'h2;
	localparam logic [4:0] SUB_DB_POS = 5'h00;
	localparam logic [4:0] SUB_DB_NEG = 5'h04;
	localparam logic [4:0] SUB_FS_POS = 5'h08;
	localparam logic [4:0] SUB_FS_NEG = 5'h0C;
	localparam logic [4:0] SUB_KINK = 5'h10;
	localparam logic [4:0] SUB_TRIM = 5'h14;
	localparam logic [4:0] SUB_OTYPE = 5'h18;

	// ==========================================================
	// field positions
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_GAIN_BIT = 1;
	localparam int CTRL_EN_BIT = 2;
	localparam int STAT_CUR_LSB = 0;
	localparam int STAT_SYNC_LSB = 2;

	// ==========================================================
	// ranges and reset values
	localparam logic [31:0] WIN_MIN = 32'h2;
	localparam logic [31:0] WIN_MAX = 32'h30D40;
	localparam logic [31:0] WIN_RST = 32'h3E8;
	localparam logic [31:0] DIST_MIN = 32'h1;
	localparam logic [31:0] DIST_MAX = 32'h2710;
	localparam logic [31:0] DIST_RST = 32'h64;
	localparam logic [31:0] GAIN_MIN = 32'h1;
	localparam logic [31:0] GAIN_MAX = 32'h190;
	localparam logic [31:0] GAIN_RST = 32'h14;
	localparam logic [31:0] LAG_MIN = 32'h1;
	localparam logic [31:0] LAG_MAX = 32'h12C;
	localparam logic [31:0] LAG_RST = 32'hA;
	localparam logic [31:0] DB_MAX = 32'h1770;
	localparam logic [31:0] FS_MIN = 32'hBB8;
	localparam logic [31:0] FS_MAX = 32'h2710;
	localparam logic [31:0] KINK_MAX = 32'hFA0;
	localparam int TRIM_LIM = 4000;
	localparam int BRAKE_GAIN_NUM = 4000;
	localparam int CORR_SHIFT = 10;
	localparam int PCT_FULL = 10000;
	localparam int VOLT_FULL_MV = 10000;
	localparam int CUR_MID_UA = 12000;
	localparam int CUR_SPAN_UA = 8000;

	typedef enum logic {
		DASY_LEADER_FOLLOWER = 1'b0,
		DASY_MEAN_TRACKING = 1'b1
	} dasy_sync_mode_type;

	typedef enum logic {
		DASY_DISTANCE_BRAKING = 1'b0,
		DASY_PROFILE = 1'b1
	} dasy_gain_mode_type;

	// bit 1 selects current, bit 0 inverts
	typedef enum logic [1:0] {
		DASY_VOLT_NORM = 2'h0,
		DASY_VOLT_INV = 2'h1,
		DASY_CUR_NORM = 2'h2,
		DASY_CUR_INV = 2'h3
	} dasy_out_type;
endpackage
`default_nettype wire

// file: verilog/dasy_out_shape.sv
`timescale 1ns/1ps
`default_nettype none
module dasy_out_shape (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// demand and settings, 0.01 % units
	input wire logic signed [16:0] demand,
	input wire logic [12:0] dbPos,
	input wire logic [12:0] dbNeg,
	input wire logic [13:0] fsPos,
	input wire logic [13:0] fsNeg,
	input wire logic [11:0] kink,
	input wire logic signed [12:0] trim,
	input wire logic [1:0] outType,
	// drive value: mV in voltage mode, uA in current mode
	output logic signed [15:0] level,
	output logic isCurrent
);
	logic signed [15:0] level_next;

	// ==========================================================
	// kinked characteristic, trim, saturation, type mapping
	always_comb begin
		int d;
		int mag;
		int db;
		int fs;
		int k;
		int sh;
		int v;
		d = int'(demand);
		mag = 0;
		db = 0;
		fs = 0;
		k = int'(kink);
		sh = 0;
		v = 0;
		if (d > dasy_pkg::PCT_FULL) d = dasy_pkg::PCT_FULL;
		if (d < -dasy_pkg::PCT_FULL) d = -dasy_pkg::PCT_FULL;
		mag = (d < 0) ? -d : d;
		db = (d < 0) ? int'(dbNeg) : int'(dbPos);
		fs = (d < 0) ? int'(fsNeg) : int'(fsPos);
		if (mag == 0) begin
			sh = 0;
		end else if (mag < k) begin
			sh = mag * db / k;
		end else begin
			sh = db + (mag - k) * (fs - db) / (dasy_pkg::PCT_FULL - k);
		end
		v = ((d < 0) ? -sh : sh) + int'(trim);
		if (v > dasy_pkg::PCT_FULL) v = dasy_pkg::PCT_FULL;
		if (v < -dasy_pkg::PCT_FULL) v = -dasy_pkg::PCT_FULL;
		if (outType[0]) v = -v;
		if (outType[1]) begin
			v = dasy_pkg::CUR_MID_UA +
				v * dasy_pkg::CUR_SPAN_UA / dasy_pkg::PCT_FULL;
		end else begin
			v = v * dasy_pkg::VOLT_FULL_MV / dasy_pkg::PCT_FULL;
		end
		level_next = 16'(v);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			level <= 16'sh0;
			isCurrent <= 1'b0;
		end else begin
			level <= level_next;
			isCurrent <= outType[1];
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_volt_range: assert property (
		!outType[1] |=> !isCurrent && level <= 16'sh2710 &&
			level >= -16'sh2710)
		else $error("voltage output outside span");
	chk_cur_range: assert property (
		outType[1] |=> isCurrent && level >= 16'sh0FA0 &&
			level <= 16'sh4E20)
		else $error("current output outside 4 to 20 mA");
	chk_zero_center: assert property (
		demand == 17'sh0 && trim == 13'sh0 && outType == 2'h2
			|=> level == 16'sh2EE0)
		else $error("zero demand not at mid current");
endmodule
`default_nettype wire

// file: verilog/dasy_sync_shaper.sv
// Notes on behaviour
// - two sync schemes selectable; axis 2 always follows in leader mode
// - mean tracking: mean position is command; both axes corrected
// - leader mode: axis 1 position is command; only axis 2 corrected
// - per-axis window 2..200000 um; flag when deviation exceeds it
// - fault flag never stops or alters the control action
// - mean tracking: each axis checked against mean with own window
// - leader mode: only axis difference checked, one common window
// - lag filter 1..300 ms precedes the proportional compensator
// - braking mode: gain from distance 1..10000 mm, shorter is higher
// - profile mode: gain taken directly, 1..400 per second
// - kinked characteristic: per-direction deadband, per-axis kink
// - per-direction full scale 3000..10000 hundredths of a percent
// - per-axis zero trim of -4000..4000 added to output
// - four output types: voltage or current, normal or inverted
// - 100 % maps to 10 V, or 4..20 mA centred on 12 mA
// - current far below 4 mA is an error and disables the module
`timescale 1ns/1ps
`default_nettype none
module dasy_sync_shaper #(
	parameter int TICK_CYCLES = dasy_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// axis positions in um and controller demands in 0.01 %
	input wire logic signed [31:0] pos1,
	input wire logic signed [31:0] pos2,
	input wire logic signed [15:0] demand1,
	input wire logic signed [15:0] demand2,
	// under-range current sense pins
	input wire logic currentBelow1,
	input wire logic currentBelow2,
	// valve drive
	output logic signed [15:0] outLevel1,
	output logic signed [15:0] outLevel2,
	output logic outCurrent1,
	output logic outCurrent2,
	output logic outEnable1,
	output logic outEnable2,
	// indications
	output logic syncFaultMsg1,
	output logic syncFaultMsg2
);
	// ==========================================================
	// registers and bus
	logic sync_mode_select_reg;
	logic gainMode_reg;
	logic enable_reg;
	logic [17:0] win_reg [2];
	logic [13:0] brakeDist_reg;
	logic [8:0] loopGain_reg;
	logic [8:0] lagTime_reg;
	logic [1:0] curFault_reg;
	logic [1:0] syncFault_reg;
	logic outEnable_reg;
	logic [31:0] prdata_next;
	logic pslverr_next;
	logic [31:0] axisRd [2];
	logic [1:0] axisHit;
	logic wrEn;

	assign wrEn = psel && penable && pwrite && pready;

	function automatic logic [31:0] clampU(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		clampU = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// no wait state: ready rises in the first access cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable && !pready;
			pslverr <= psel && !penable && !pready && pslverr_next;
			if (psel && !penable && !pwrite) prdata <= prdata_next;
		end
	end

	always_comb begin
		prdata_next = 32'h0;
		pslverr_next = 1'b0;
		unique case (paddr)
			dasy_pkg::OFS_CTRL: prdata_next = {29'h0, enable_reg,
				gainMode_reg, sync_mode_select_reg};
			dasy_pkg::OFS_WIN1: prdata_next = {14'h0, win_reg[0]};
			dasy_pkg::OFS_WIN2: prdata_next = {14'h0, win_reg[1]};
			dasy_pkg::OFS_BRAKE: prdata_next = {18'h0, brakeDist_reg};
			dasy_pkg::OFS_LOOPG: prdata_next = {23'h0, loopGain_reg};
			dasy_pkg::OFS_LAG: prdata_next = {23'h0, lagTime_reg};
			dasy_pkg::OFS_STATUS: prdata_next = {28'h0, syncFault_reg,
				curFault_reg};
			default: begin
				if (axisHit[0]) prdata_next = axisRd[0];
				else if (axisHit[1]) prdata_next = axisRd[1];
				else pslverr_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sync_mode_select_reg <= dasy_pkg::DASY_LEADER_FOLLOWER;
			gainMode_reg <= dasy_pkg::DASY_DISTANCE_BRAKING;
			enable_reg <= 1'b0;
			win_reg[0] <= 18'(dasy_pkg::WIN_RST);
			win_reg[1] <= 18'(dasy_pkg::WIN_RST);
			brakeDist_reg <= 14'(dasy_pkg::DIST_RST);
			loopGain_reg <= 9'(dasy_pkg::GAIN_RST);
			lagTime_reg <= 9'(dasy_pkg::LAG_RST);
		end else if (wrEn) begin
			unique case (paddr)
				dasy_pkg::OFS_CTRL: begin
					sync_mode_select_reg <= pwdata[dasy_pkg::CTRL_MODE_BIT];
					gainMode_reg <= pwdata[dasy_pkg::CTRL_GAIN_BIT];
					enable_reg <= pwdata[dasy_pkg::CTRL_EN_BIT];
				end
				dasy_pkg::OFS_WIN1: win_reg[0] <= 18'(clampU(pwdata,
					dasy_pkg::WIN_MIN, dasy_pkg::WIN_MAX));
				dasy_pkg::OFS_WIN2: win_reg[1] <= 18'(clampU(pwdata,
					dasy_pkg::WIN_MIN, dasy_pkg::WIN_MAX));
				dasy_pkg::OFS_BRAKE: brakeDist_reg <= 14'(clampU(pwdata,
					dasy_pkg::DIST_MIN, dasy_pkg::DIST_MAX));
				dasy_pkg::OFS_LOOPG: loopGain_reg <= 9'(clampU(pwdata,
					dasy_pkg::GAIN_MIN, dasy_pkg::GAIN_MAX));
				dasy_pkg::OFS_LAG: lagTime_reg <= 9'(clampU(pwdata,
					dasy_pkg::LAG_MIN, dasy_pkg::LAG_MAX));
				default: ;
			endcase
		end
	end

	// ==========================================================
	// synchronisation error, lag filter and gain
	logic signed [32:0] posSum;
	logic signed [31:0] meanPos;
	logic signed [31:0] err [2];
	logic [31:0] absErr [2];
	logic signed [31:0] filt_reg [2];
	logic signed [15:0] corr_reg [2];
	logic [11:0] gain_reg;
	logic [15:0] tickCnt_reg;
	logic tick_reg;

	assign posSum = 33'(pos1) + 33'(pos2);
	assign meanPos = posSum[32:1];

	always_comb begin
		if (sync_mode_select_reg == dasy_pkg::DASY_MEAN_TRACKING) begin
			err[0] = meanPos - pos1;
			err[1] = meanPos - pos2;
		end else begin
			err[0] = 32'sh0;
			err[1] = pos1 - pos2;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tickCnt_reg <= 16'h0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (tickCnt_reg == 16'(TICK_CYCLES - 1));
			if (tickCnt_reg == 16'(TICK_CYCLES - 1)) tickCnt_reg <= 16'h0;
			else tickCnt_reg <= tickCnt_reg + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gain_reg <= 12'h0;
		end else if (gainMode_reg == dasy_pkg::DASY_PROFILE) begin
			gain_reg <= {3'h0, loopGain_reg};
		end else begin
			gain_reg <= 12'(dasy_pkg::BRAKE_GAIN_NUM /
				int'(brakeDist_reg));
		end
	end

	// ==========================================================
	// per-axis filter, correction, monitoring and output stage
	logic signed [16:0] shapeIn [2];
	logic signed [15:0] level [2];
	logic [1:0] isCur;
	logic [1:0] belowMeta_reg;
	logic [1:0] belowSync_reg;
	logic [1:0] curTrip;

	for (genvar i = 0; i < 2; i++) begin : g_axis
		logic [12:0] dbPos_reg;
		logic [12:0] dbNeg_reg;
		logic [13:0] fsPos_reg;
		logic [13:0] fsNeg_reg;
		logic [11:0] kink_reg;
		logic signed [12:0] trim_reg;
		logic [1:0] otype_reg;
		logic [4:0] sub;
		logic signed [43:0] prod;
		logic signed [31:0] trimIn;
		logic [17:0] winUsed;

		assign axisHit[i] = (paddr[7:5] == ((i == 0) ?
			dasy_pkg::AXIS1_PAGE : dasy_pkg::AXIS2_PAGE)) &&
			(paddr[4:0] <= dasy_pkg::SUB_OTYPE) && (paddr[1:0] == 2'h0);
		assign sub = paddr[4:0];
		assign trimIn = $signed(pwdata);

		always_comb begin
			unique case (sub)
				dasy_pkg::SUB_DB_POS: axisRd[i] = {19'h0, dbPos_reg};
				dasy_pkg::SUB_DB_NEG: axisRd[i] = {19'h0, dbNeg_reg};
				dasy_pkg::SUB_FS_POS: axisRd[i] = {18'h0, fsPos_reg};
				dasy_pkg::SUB_FS_NEG: axisRd[i] = {18'h0, fsNeg_reg};
				dasy_pkg::SUB_KINK: axisRd[i] = {20'h0, kink_reg};
				dasy_pkg::SUB_TRIM: axisRd[i] = 32'(trim_reg);
				default: axisRd[i] = {30'h0, otype_reg};
			endcase
		end

		always_ff @(posedge clk) begin
			if (reset) begin
				dbPos_reg <= 13'h0;
				dbNeg_reg <= 13'h0;
				fsPos_reg <= 14'(dasy_pkg::FS_MAX);
				fsNeg_reg <= 14'(dasy_pkg::FS_MAX);
				kink_reg <= 12'h0;
				trim_reg <= 13'sh0;
				otype_reg <= dasy_pkg::DASY_VOLT_NORM;
			end else if (wrEn && axisHit[i]) begin
				unique case (sub)
					dasy_pkg::SUB_DB_POS: dbPos_reg <= 13'(clampU(pwdata,
						32'h0, dasy_pkg::DB_MAX));
					dasy_pkg::SUB_DB_NEG: dbNeg_reg <= 13'(clampU(pwdata,
						32'h0, dasy_pkg::DB_MAX));
					dasy_pkg::SUB_FS_POS: fsPos_reg <= 14'(clampU(pwdata,
						dasy_pkg::FS_MIN, dasy_pkg::FS_MAX));
					dasy_pkg::SUB_FS_NEG: fsNeg_reg <= 14'(clampU(pwdata,
						dasy_pkg::FS_MIN, dasy_pkg::FS_MAX));
					dasy_pkg::SUB_KINK: kink_reg <= 12'(clampU(pwdata,
						32'h0, dasy_pkg::KINK_MAX));
					dasy_pkg::SUB_TRIM: trim_reg <= 13'(
						(trimIn > dasy_pkg::TRIM_LIM) ? dasy_pkg::TRIM_LIM :
						(trimIn < -dasy_pkg::TRIM_LIM) ? -dasy_pkg::TRIM_LIM :
						trimIn);
					default: otype_reg <= pwdata[1:0];
				endcase
			end
		end

		// lag filter steps once per millisecond tick
		always_ff @(posedge clk) begin
			if (reset) begin
				filt_reg[i] <= 32'sh0;
			end else if (tick_reg) begin
				filt_reg[i] <= filt_reg[i] + (err[i] - filt_reg[i]) /
					$signed({23'h0, lagTime_reg});
			end
		end

		assign prod = 44'(filt_reg[i]) * $signed({32'h0, gain_reg});

		always_ff @(posedge clk) begin
			if (reset) begin
				corr_reg[i] <= 16'sh0;
			end else if (prod >>> dasy_pkg::CORR_SHIFT >
				44'(dasy_pkg::PCT_FULL)) begin
				corr_reg[i] <= 16'(dasy_pkg::PCT_FULL);
			end else if (prod >>> dasy_pkg::CORR_SHIFT <
				-44'(dasy_pkg::PCT_FULL)) begin
				corr_reg[i] <= -16'(dasy_pkg::PCT_FULL);
			end else begin
				corr_reg[i] <= 16'(prod >>> dasy_pkg::CORR_SHIFT);
			end
		end

		// in leader mode both windows act as the first one
		assign winUsed = sync_mode_select_reg ? win_reg[i] : win_reg[0];
		assign absErr[i] = sync_mode_select_reg ?
			((err[i] < 0) ? 32'(-err[i]) : 32'(err[i])) :
			((err[1] < 0) ? 32'(-err[1]) : 32'(err[1]));

		always_ff @(posedge clk) begin
			if (reset) syncFault_reg[i] <= 1'b0;
			else syncFault_reg[i] <= absErr[i] > {14'h0, winUsed};
		end

		// correction adds to the demand; the fault flag has no say
		assign shapeIn[i] = 17'((i == 0) ? demand1 : demand2) +
			17'(corr_reg[i]);

		dasy_out_shape u_shape (
			.clk(clk),
			.reset(reset),
			.demand(shapeIn[i]),
			.dbPos(dbPos_reg),
			.dbNeg(dbNeg_reg),
			.fsPos(fsPos_reg),
			.fsNeg(fsNeg_reg),
			.kink(kink_reg),
			.trim(trim_reg),
			.outType(otype_reg),
			.level(level[i]),
			.isCurrent(isCur[i])
		);

		assign curTrip[i] = belowSync_reg[i] && isCur[i] && outEnable_reg;

		// a new trip in the clearing cycle keeps the flag set
		always_ff @(posedge clk) begin
			if (reset) curFault_reg[i] <= 1'b0;
			else if (curTrip[i]) curFault_reg[i] <= 1'b1;
			else if (wrEn && paddr == dasy_pkg::OFS_STATUS &&
				pwdata[dasy_pkg::STAT_CUR_LSB + i]) curFault_reg[i] <= 1'b0;
		end
	end

	// ==========================================================
	// pin synchroniser and output enable
	always_ff @(posedge clk) begin
		if (reset) begin
			belowMeta_reg <= 2'h0;
			belowSync_reg <= 2'h0;
		end else begin
			belowMeta_reg <= {currentBelow2, currentBelow1};
			belowSync_reg <= belowMeta_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) outEnable_reg <= 1'b0;
		else outEnable_reg <= enable_reg && curFault_reg == 2'h0;
	end

	assign outLevel1 = level[0];
	assign outLevel2 = level[1];
	assign outCurrent1 = isCur[0];
	assign outCurrent2 = isCur[1];
	assign outEnable1 = outEnable_reg;
	assign outEnable2 = outEnable_reg;
	assign syncFaultMsg1 = syncFault_reg[0];
	assign syncFaultMsg2 = syncFault_reg[1];

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_trip;
		(curTrip != 2'h0) ##1 (curFault_reg != 2'h0);
	endsequence

	chk_leader_corr: assert property (
		!sync_mode_select_reg && tick_reg && lagTime_reg == 9'h1 |=>
			filt_reg[0] == 32'sh0)
		else $error("leader axis receives correction");
	chk_mean_sym: assert property (
		sync_mode_select_reg |-> (err[0] + err[1] == 32'sh0) ||
			(err[0] + err[1] == -32'sh1))
		else $error("mean corrections not opposed");
	chk_win_flag: assert property (
		sync_mode_select_reg && absErr[0] > {14'h0, win_reg[0]} |=> syncFaultMsg1)
		else $error("window breach not flagged");
	chk_leader_win: assert property (
		!sync_mode_select_reg && absErr[1] <= {14'h0, win_reg[0]} |=>
			!syncFaultMsg1 && !syncFaultMsg2)
		else $error("common window misused");
	chk_fault_runs: assert property (
		syncFaultMsg1 && enable_reg && curFault_reg == 2'h0 |=> outEnable1)
		else $error("sync fault stopped the output");
	chk_filter_hold: assert property (
		!tick_reg |=> $stable(filt_reg[1]))
		else $error("lag filter moved off tick");
	chk_profile_gain: assert property (
		(gainMode_reg && $stable(loopGain_reg)) [*2] |->
			gain_reg == {3'h0, loopGain_reg})
		else $error("profile gain not applied");
	chk_brake_gain: assert property (
		(!gainMode_reg && $stable(brakeDist_reg) &&
			brakeDist_reg > 14'h1) [*2] |->
			gain_reg < 12'(dasy_pkg::BRAKE_GAIN_NUM))
		else $error("braking gain not reduced by distance");
	chk_under_cur: assert property (
		s_trip |=> !outEnable1 && !outEnable2)
		else $error("module not disabled on low current");
	chk_apb_wait: assert property (
		psel && !penable && !pready |=> pready ##1 !pready)
		else $error("ready timing wrong");
endmodule
`default_nettype wire

// file: verification/dasy_valve_model.sv
`timescale 1ns/1ps
`default_nettype none
module dasy_valve_model (
	// clock
	input wire logic clk,
	// drive from the block
	input wire logic signed [15:0] level,
	input wire logic isCurrent,
	input wire logic enable,
	// sensor and fault stimulus
	input wire logic signed [31:0] posIn,
	input wire logic wireOpen,
	output logic signed [31:0] pos,
	output logic currentLow
);
	// ==========================================================
	// position sensor
	always_ff @(posedge clk) begin
		pos <= posIn;
	end
	// ==========================================================
	// valve supervises its current and drops out below 4 mA
	always_ff @(posedge clk) begin
		currentLow <= isCurrent && enable
			&& (wireOpen || level < 16'sd4000);
	end
	// no valve response modelled; pos only follows posIn
endmodule
`default_nettype wire

// file: verification/dual_axis_sync_output_shaping_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_axis_sync_output_shaping_test;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, wireOpen2 = 0;
	logic signed [31:0] pos1, pos2, posSet1 = '0, posSet2 = '0;
	logic signed [15:0] demand1 = '0, demand2 = '0, outLevel1, outLevel2;
	logic currentBelow1, currentBelow2, outCurrent1, outCurrent2;
	logic outEnable1, outEnable2, syncFaultMsg1, syncFaultMsg2;
	int n_fail = 0, tests_run = 0, seed = 32'h9E45, e1, e2;

	dasy_sync_shaper #(.TICK_CYCLES(8)) u_dasy_sync_shaper (.clk(clk),
		.reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pos1(pos1), .pos2(pos2), .demand1(demand1),
		.demand2(demand2), .currentBelow1(currentBelow1),
		.currentBelow2(currentBelow2), .outLevel1(outLevel1),
		.outLevel2(outLevel2), .outCurrent1(outCurrent1),
		.outCurrent2(outCurrent2), .outEnable1(outEnable1),
		.outEnable2(outEnable2), .syncFaultMsg1(syncFaultMsg1),
		.syncFaultMsg2(syncFaultMsg2));
	dasy_valve_model u_dasy_valve_model1 (.clk(clk), .level(outLevel1),
		.isCurrent(outCurrent1), .enable(outEnable1), .posIn(posSet1),
		.wireOpen(1'b0), .pos(pos1), .currentLow(currentBelow1));
	dasy_valve_model u_dasy_valve_model2 (.clk(clk), .level(outLevel2),
		.isCurrent(outCurrent2), .enable(outEnable2), .posIn(posSet2),
		.wireOpen(wireOpen2), .pos(pos2), .currentLow(currentBelow2));

	// ==========================================================
	// reporting
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic signed [31:0] seen, exp, input string m);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t %s seen %0d exp %0d", $time, m, seen, exp);
		end
	endtask

	// ==========================================================
	// apb master
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			n_fail++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cfg(input logic [2:0] pg, input int dp, dn, fp, fn, k, t);
		apb(1, {pg, dasy_pkg::SUB_DB_POS}, 32'(dp));
		apb(1, {pg, dasy_pkg::SUB_DB_NEG}, 32'(dn));
		apb(1, {pg, dasy_pkg::SUB_FS_POS}, 32'(fp));
		apb(1, {pg, dasy_pkg::SUB_FS_NEG}, 32'(fn));
		apb(1, {pg, dasy_pkg::SUB_KINK}, 32'(k));
		apb(1, {pg, dasy_pkg::SUB_TRIM}, 32'(t));
	endtask

	// ==========================================================
	// expected drive value
	function automatic int shape(int d, dp, dn, fp, fn, k, t, ty);
		int m, b, f, v;
		m = d < 0 ? -d : d;
		b = d < 0 ? dn : dp;
		f = d < 0 ? fn : fp;
		if (m < k)
			v = m * b / k;
		else
			v = b + (m - k) * (f - b) / (10000 - k);
		v = (d < 0 ? -v : v) + t;
		v = v > 10000 ? 10000 : (v < -10000 ? -10000 : v);
		if (ty % 2 == 1)
			v = -v;
		return ty >= 2 ? 12000 + v * 4 / 5 : v;
	endfunction

	function automatic int exp1(int d, ty);
		return shape(d, 2000, 1000, 7000, 6000, 0, 500, ty);
	endfunction

	function automatic int exp2(int d);
		return shape(d, 1000, 1000, 9000, 9000, 2000, 4000, 3);
	endfunction

	initial begin
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		apb(0, dasy_pkg::OFS_WIN1, 0);
		check(rd, dasy_pkg::WIN_RST, "win reset");
		apb(0, dasy_pkg::OFS_LAG, 0);
		check(rd, dasy_pkg::LAG_RST, "lag reset");
		apb(0, {dasy_pkg::AXIS1_PAGE, dasy_pkg::SUB_FS_POS}, 0);
		check(rd, dasy_pkg::FS_MAX, "fs reset");
		apb(0, 8'hFC, 0);
		check(err, 1, "unmapped err");
		check(rd, 0, "unmapped data");
		apb(1, dasy_pkg::OFS_WIN1, 1);
		apb(0, dasy_pkg::OFS_WIN1, 0);
		check(rd, dasy_pkg::WIN_MIN, "win clamp");
		apb(1, dasy_pkg::OFS_LOOPG, 32'h1000);
		apb(0, dasy_pkg::OFS_LOOPG, 0);
		check(rd, dasy_pkg::GAIN_MAX, "gain clamp");
		apb(1, dasy_pkg::OFS_LAG, 1);
		$display("registers done");
		cfg(dasy_pkg::AXIS1_PAGE, 2000, 1000, 7000, 6000, 0, 500);
		cfg(dasy_pkg::AXIS2_PAGE, 1000, 1000, 9000, 9000, 2000, 4000);
		apb(1, {dasy_pkg::AXIS2_PAGE, dasy_pkg::SUB_OTYPE}, 3);
		apb(1, dasy_pkg::OFS_CTRL, 32'h6);
		demand1 <= 16'sd4000;
		for (int ty = 0; ty < 4; ty++) begin
			apb(1, {dasy_pkg::AXIS1_PAGE, dasy_pkg::SUB_OTYPE}, 32'(ty));
			repeat (3) @(posedge clk);
			check(outLevel1, exp1(4000, ty), "type level");
			check(outCurrent1, ty / 2, "type current");
		end
		apb(1, {dasy_pkg::AXIS1_PAGE, dasy_pkg::SUB_OTYPE}, 2);
		apb(1, {dasy_pkg::AXIS1_PAGE, dasy_pkg::SUB_TRIM}, 0);
		demand1 <= 16'sd0;
		repeat (3) @(posedge clk);
		check(outLevel1, 12000, "mid current");
		check(outCurrent2, 1, "current 2");
		apb(1, {dasy_pkg::AXIS1_PAGE, dasy_pkg::SUB_TRIM}, 500);
		apb(1, {dasy_pkg::AXIS1_PAGE, dasy_pkg::SUB_OTYPE}, 0);
		$display("output types done");
		for (int i = 0; i < 24; i++) begin
			e1 = ($random(seed) % 1000) * 10;
			e1 = e1 == 0 ? 10 : e1;
			e2 = i < 2 ? (i == 0 ? 10000 : -10000) : ($random(seed) % 1001) * 10;
			demand1 <= 16'(e1);
			demand2 <= 16'(e2);
			repeat (3) @(posedge clk);
			check(outLevel1, exp1(e1, 0), "shape 1");
			check(outLevel2, exp2(e2), "shape 2");
		end
		$display("shaping done");
		// the valve model passes posSet straight through; demands only set the levels
		apb(1, dasy_pkg::OFS_WIN1, 1000);
		apb(1, dasy_pkg::OFS_WIN2, 2000);
		demand1 <= 16'sd2000;
		demand2 <= 16'sd2000;
		posSet2 <= 3000;
		apb(1, dasy_pkg::OFS_CTRL, 32'h5);
		repeat (200) @(posedge clk);
		check(syncFaultMsg1, 1, "mean flag 1");
		check(syncFaultMsg2, 0, "mean flag 2");
		check(outEnable1, 1, "runs on fault");
		check(outLevel1 !== exp1(2000, 0), 1, "corr 1");
		check(outLevel2 !== exp2(2000), 1, "corr 2");
		apb(1, dasy_pkg::OFS_CTRL, 32'h6);
		repeat (200) @(posedge clk);
		check(syncFaultMsg1, 1, "lf flag 1");
		check(syncFaultMsg2, 1, "lf flag 2");
		check(outLevel1, exp1(2000, 0), "leader free");
		check(outLevel2 !== exp2(2000), 1, "follower corr");
		posSet2 <= 500;
		repeat (50) @(posedge clk);
		check(syncFaultMsg1, 0, "lf clear 1");
		check(syncFaultMsg2, 0, "lf clear 2");
		$display("sync done");
		wireOpen2 <= 1'b1;
		repeat (10) @(posedge clk);
		check(outEnable1, 0, "trip off 1");
		check(outEnable2, 0, "trip off 2");
		wireOpen2 <= 1'b0;
		apb(0, dasy_pkg::OFS_STATUS, 0);
		check(rd[1:0], 2, "trip status");
		apb(1, dasy_pkg::OFS_STATUS, 2);
		apb(0, dasy_pkg::OFS_STATUS, 0);
		check(rd[1:0], 0, "trip cleared");
		$display("under-current done");
		close_out();
	end
endmodule
`default_nettype wire
